// ===== design/sqs_pkg.sv
// Shared constants and types for the sequencer state and dynamic select block.
package sqs_pkg;

	// Status word layout.
	localparam int SQS_STAT_W = 32;
	localparam int SQS_IDX_W = 25;
	localparam int SQS_IDX_LSB = 0;
	localparam int SQS_STATE_LSB = 25;
	localparam int SQS_STATE_W = 2;
	localparam int SQS_RSVD_LSB = 27;
	localparam int SQS_RSVD_W = 5;
	localparam logic [4:0] SQS_RSVD_VAL = 5'h00;

	// Execution state codes as reported in the status word.
	localparam logic [1:0] SQS_CODE_IDLE = 2'h0;
	localparam logic [1:0] SQS_CODE_WAIT_TRIG = 2'h1;
	localparam logic [1:0] SQS_CODE_RUN = 2'h2;
	localparam logic [1:0] SQS_CODE_WAIT_ADV = 2'h3;

	// Reset values of the host settings.
	localparam logic [24:0] SQS_SEL_RST = 25'h0000000;
	localparam logic SQS_DYN_RST = 1'b0;

	// Remote command codes.
	typedef enum logic [3:0] {
		SQS_CMD_NONE = 4'h0,
		SQS_CMD_DYN_EN_WR = 4'h1,
		SQS_CMD_DYN_EN_RD = 4'h2,
		SQS_CMD_NEXT_SEL_WR = 4'h3,
		SQS_CMD_SEQ_SEL_WR = 4'h4,
		SQS_CMD_SEQ_SEL_RD = 4'h5,
		SQS_CMD_SCEN_SEL_WR = 4'h6,
		SQS_CMD_SCEN_SEL_RD = 4'h7,
		SQS_CMD_SEG_SEL_WR = 4'h8,
		SQS_CMD_SEG_SEL_RD = 4'h9,
		SQS_CMD_STATE_QUERY = 4'ha
	} sqs_cmd_type;

	// Play modes.
	typedef enum logic [1:0] {
		SQS_MODE_ARB = 2'h0,
		SQS_MODE_SEQ = 2'h1,
		SQS_MODE_SCEN = 2'h2
	} sqs_mode_type;

	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		SQS_ST_IDLE = 4'b0001,
		SQS_ST_WAIT_TRIG = 4'b0010,
		SQS_ST_RUN = 4'b0100,
		SQS_ST_WAIT_ADV = 4'b1000
	} sqs_state_type;

endpackage : sqs_pkg

// ===== design/sqs_reply.sv
// Reply register that holds one answer word and marks it with a one-cycle valid.
`timescale 1ns/1ns
module sqs_reply #(
	parameter int WORD_W = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [WORD_W-1:0] word_i,
	output logic resp_valid_o,
	output logic [WORD_W-1:0] resp_data_o
);

	logic next_valid;
	logic [WORD_W-1:0] next_data;

	// The word is captured whole in the load cycle, so its fields never mix two cycles.
	always_comb begin
		next_valid = load_i;
		next_data = load_i ? word_i : resp_data_o;
	end

	// Register stage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_valid_o <= 1'b0;
			resp_data_o <= '0;
		end else begin
			resp_valid_o <= next_valid;
			resp_data_o <= next_data;
		end
	end

endmodule : sqs_reply

// ===== design/sqs_core.sv
// Sequencer execution state, status word and dynamic entry selection.
// Behaviour
// - Status query returns one 32-bit word; bits 31:27 are reserved zero.
// - Bits 26:25 hold state: 0 idle, 1 trigger wait, 2 running, 3 advance wait.
// - Bits 24:0 hold the index of the entry now executing.
// - While idle the index field is meaningless to the reader.
// - Dynamic off: segment or sequence changes accepted only while generation is stopped.
// - Dynamic off: segment select and sequence start select set the new entry.
// - Dynamic on: selection may change while generation keeps running.
// - Dynamic on: next entry comes from host select or external select port, except in scenario mode.
// - External select value is used directly as a sequence table index.
// - Host next-entry select names the entry executed next outside scenario mode; written only when dynamic.
// - Scenario mode starts at scenario start select, which reads back.
// - Sequence mode starts at sequence start select.
// - In sequence mode, dynamic mode plays sequence start select until first dynamic choice.
`timescale 1ns/1ns
module sqs_core
	import sqs_pkg::*;
#(
	parameter int IDX_W = 25
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire sqs_pkg::sqs_cmd_type cmd_code_i,
	input wire logic [31:0] cmd_data_i,
	input wire sqs_pkg::sqs_mode_type play_mode_i,
	input wire logic run_i,
	input wire logic stop_i,
	input wire logic trigger_i,
	input wire logic entry_done_i,
	input wire logic need_advance_i,
	input wire logic advance_i,
	input wire logic ext_sel_valid_i,
	input wire logic [IDX_W-1:0] ext_sel_i,
	output logic resp_valid_o,
	output logic [31:0] resp_data_o,
	output logic cmd_refused_o,
	output sqs_pkg::sqs_state_type seq_state_o,
	output logic [IDX_W-1:0] entry_index_o
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.
	// Maps the one-hot state to its reported two-bit code.
	function automatic logic [1:0] state_code(input sqs_state_type st);
		logic [1:0] code;
		code = SQS_CODE_IDLE;
		unique case (st)
			SQS_ST_IDLE: code = SQS_CODE_IDLE;
			SQS_ST_WAIT_TRIG: code = SQS_CODE_WAIT_TRIG;
			SQS_ST_RUN: code = SQS_CODE_RUN;
			SQS_ST_WAIT_ADV: code = SQS_CODE_WAIT_ADV;
			default: code = SQS_CODE_IDLE;
		endcase
		return code;
	endfunction : state_code

	// Pads an index into a 32-bit reply word.
	function automatic logic [31:0] pad_idx(input logic [IDX_W-1:0] v);
		return {{(32-IDX_W){1'b0}}, v};
	endfunction : pad_idx

	////////////////////////////////////////////////////////////////////////
	// Host settings and dynamic selection.
	logic dyn_en, next_dyn_en;
	logic [IDX_W-1:0] seq_sel, next_seq_sel;
	logic [IDX_W-1:0] scen_sel, next_scen_sel;
	logic [IDX_W-1:0] seg_sel, next_seg_sel;
	logic [IDX_W-1:0] dyn_next, next_dyn_next;
	logic dyn_pending, next_dyn_pending;
	logic next_refused, stopped, take_dyn, reply_load;
	logic [31:0] reply_word, status_word;

	assign stopped = (seq_state_o == SQS_ST_IDLE);
	// Status fields come from the same registered state and index in one cycle.
	assign status_word = {SQS_RSVD_VAL, state_code(seq_state_o), entry_index_o};

	// Settings writes; static-mode selection changes are refused while generating.
	always_comb begin
		next_dyn_en = dyn_en;
		next_seq_sel = seq_sel;
		next_scen_sel = scen_sel;
		next_seg_sel = seg_sel;
		next_dyn_next = dyn_next;
		next_dyn_pending = dyn_pending;
		next_refused = 1'b0;
		// A consumed dynamic choice clears the pending flag unless a new one lands.
		if (take_dyn) begin
			next_dyn_pending = 1'b0;
		end
		// External port selects by index; it wins only when no host next-select write arrives in the same cycle.
		if (dyn_en && ext_sel_valid_i) begin
			next_dyn_next = ext_sel_i;
			next_dyn_pending = 1'b1;
		end
		if (cmd_valid_i) begin
			unique case (cmd_code_i)
				SQS_CMD_DYN_EN_WR: begin
					if (stopped) begin
						next_dyn_en = cmd_data_i[0];
					end else begin
						next_refused = 1'b1;
					end
				end
				SQS_CMD_NEXT_SEL_WR: begin
					if (dyn_en) begin
						next_dyn_next = cmd_data_i[IDX_W-1:0];
						next_dyn_pending = 1'b1;
					end else begin
						next_refused = 1'b1;
					end
				end
				SQS_CMD_SEQ_SEL_WR: begin
					if (stopped || dyn_en) begin
						next_seq_sel = cmd_data_i[IDX_W-1:0];
					end else begin
						next_refused = 1'b1;
					end
				end
				SQS_CMD_SEG_SEL_WR: begin
					if (stopped || dyn_en) begin
						next_seg_sel = cmd_data_i[IDX_W-1:0];
					end else begin
						next_refused = 1'b1;
					end
				end
				SQS_CMD_SCEN_SEL_WR: begin
					if (stopped) begin
						next_scen_sel = cmd_data_i[IDX_W-1:0];
					end else begin
						next_refused = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Settings registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dyn_en <= SQS_DYN_RST;
			seq_sel <= SQS_SEL_RST[IDX_W-1:0];
			scen_sel <= SQS_SEL_RST[IDX_W-1:0];
			seg_sel <= SQS_SEL_RST[IDX_W-1:0];
			dyn_next <= SQS_SEL_RST[IDX_W-1:0];
			dyn_pending <= 1'b0;
			cmd_refused_o <= 1'b0;
		end else begin
			dyn_en <= next_dyn_en;
			seq_sel <= next_seq_sel;
			scen_sel <= next_scen_sel;
			seg_sel <= next_seg_sel;
			dyn_next <= next_dyn_next;
			dyn_pending <= next_dyn_pending;
			cmd_refused_o <= next_refused;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer state machine.
	sqs_state_type next_state;
	logic [IDX_W-1:0] next_index, start_index;

	// Start entry depends on the play mode only; dynamic on does not change it, so sequence mode begins at sequence start.
	always_comb begin
		unique case (play_mode_i)
			SQS_MODE_ARB: start_index = seg_sel;
			SQS_MODE_SEQ: start_index = seq_sel;
			SQS_MODE_SCEN: start_index = scen_sel;
			default: start_index = seq_sel;
		endcase
	end

	// Outside scenario mode, a pending dynamic choice replaces the usual next entry at an entry boundary.
	assign take_dyn = dyn_en && dyn_pending && !stopped && (play_mode_i != SQS_MODE_SCEN) &&
		((seq_state_o == SQS_ST_RUN && entry_done_i && !need_advance_i) ||
		(seq_state_o == SQS_ST_WAIT_ADV && advance_i));

	// Next state and next entry index.
	always_comb begin
		next_state = seq_state_o;
		next_index = entry_index_o;
		if (stop_i) begin
			next_state = SQS_ST_IDLE;
		end else begin
			unique case (seq_state_o)
				SQS_ST_IDLE: begin
					if (run_i) begin
						next_state = SQS_ST_WAIT_TRIG;
						next_index = start_index;
					end
				end
				SQS_ST_WAIT_TRIG: begin
					if (trigger_i) begin
						next_state = SQS_ST_RUN;
					end
				end
				SQS_ST_RUN: begin
					if (entry_done_i && need_advance_i) begin
						next_state = SQS_ST_WAIT_ADV;
					end else if (entry_done_i) begin
						next_index = take_dyn ? dyn_next : entry_index_o + 1'b1;
					end
				end
				SQS_ST_WAIT_ADV: begin
					if (advance_i) begin
						next_state = SQS_ST_RUN;
						next_index = take_dyn ? dyn_next : entry_index_o + 1'b1;
					end
				end
				default: next_state = SQS_ST_IDLE;
			endcase
		end
	end

	// State registers; the index keeps its last value in idle, where it has no meaning.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_state_o <= SQS_ST_IDLE;
			entry_index_o <= '0;
		end else begin
			seq_state_o <= next_state;
			entry_index_o <= next_index;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Query replies.
	// Queries only read; nothing in the sequencer changes on a read.
	always_comb begin
		reply_load = cmd_valid_i;
		reply_word = 32'h00000000;
		unique case (cmd_code_i)
			SQS_CMD_STATE_QUERY: reply_word = status_word;
			SQS_CMD_DYN_EN_RD: reply_word = {31'h00000000, dyn_en};
			SQS_CMD_SEQ_SEL_RD: reply_word = pad_idx(seq_sel);
			SQS_CMD_SCEN_SEL_RD: reply_word = pad_idx(scen_sel);
			SQS_CMD_SEG_SEL_RD: reply_word = pad_idx(seg_sel);
			default: reply_load = 1'b0;
		endcase
	end

	sqs_reply #(.WORD_W(32)) u_reply (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(reply_load),
		.word_i(reply_word),
		.resp_valid_o(resp_valid_o),
		.resp_data_o(resp_data_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks.
	status_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(cmd_valid_i && cmd_code_i == SQS_CMD_STATE_QUERY) |-> resp_valid_o && resp_data_o[31:27] == 5'h00)
		else $error("status reply missing or reserved bits set");
	status_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(cmd_valid_i && cmd_code_i == SQS_CMD_STATE_QUERY) |->
		resp_data_o[26:25] == state_code($past(seq_state_o)))
		else $error("status state code wrong");
	status_index_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(cmd_valid_i && cmd_code_i == SQS_CMD_STATE_QUERY) |-> resp_data_o[24:0] == $past(entry_index_o))
		else $error("status index wrong");
	static_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_valid_i && cmd_code_i == SQS_CMD_SEQ_SEL_WR && !dyn_en && !stopped |=> cmd_refused_o && $stable(seq_sel))
		else $error("static sequence change taken while running");
	static_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_valid_i && cmd_code_i == SQS_CMD_SEG_SEL_WR && stopped |=> seg_sel == $past(cmd_data_i[IDX_W-1:0]))
		else $error("segment select not stored while stopped");
	dyn_jump_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take_dyn && !stop_i |=> entry_index_o == $past(dyn_next) && seq_state_o == SQS_ST_RUN)
		else $error("dynamic entry not taken");
	ext_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dyn_en && ext_sel_valid_i && !(cmd_valid_i && cmd_code_i == SQS_CMD_NEXT_SEL_WR) |=>
		dyn_pending && dyn_next == $past(ext_sel_i))
		else $error("external select value not latched");
	next_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_valid_i && cmd_code_i == SQS_CMD_NEXT_SEL_WR && !dyn_en |=> cmd_refused_o && !$rose(dyn_pending))
		else $error("next select accepted with dynamic off");
	start_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stopped && run_i && !stop_i && play_mode_i == SQS_MODE_SCEN |=>
		seq_state_o == SQS_ST_WAIT_TRIG && entry_index_o == $past(scen_sel))
		else $error("scenario did not start at its start entry");
	query_clean_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_valid_i && cmd_code_i == SQS_CMD_STATE_QUERY && !run_i && !stop_i && !trigger_i && !entry_done_i &&
		!advance_i |=> $stable(seq_state_o) && $stable(entry_index_o))
		else $error("status read disturbed the sequencer");

endmodule : sqs_core

// ===== verification/sqs_ext_sel_model.sv
// Behavioural model of the external dynamic select port feeding the sequencer.
`timescale 1ns/1ns
module sqs_ext_sel_model (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic [24:0] val_i,
	output logic ext_sel_valid_o,
	output logic [24:0] ext_sel_o
);
	logic req;
	logic [24:0] held;
	// The request is caught on the rising edge, so bench and model never race.
	always @(posedge clk_i) begin
		req <= send_i;
		held <= val_i;
	end
	// Outside a pulse the value flips every cycle, so a stale index never looks steady.
	always @(negedge clk_i) begin
		ext_sel_valid_o <= req;
		ext_sel_o <= req ? held : ~ext_sel_o;
	end
	// Quiet port at time zero.
	initial begin
		ext_sel_valid_o = 1'b0;
		ext_sel_o = 25'h0000000;
	end
endmodule : sqs_ext_sel_model

// ===== verification/sequencer_state_and_dynamic_select_tb_top.sv
// Self-checking bench for the sequencer state and dynamic select core.
`timescale 1ns/1ns
module sequencer_state_and_dynamic_select_tb_top;
	import sqs_pkg::*;
	localparam logic [5:0] RUN = 6'h20;
	localparam logic [5:0] STOP = 6'h10;
	localparam logic [5:0] TRIG = 6'h08;
	localparam logic [5:0] DONE = 6'h04;
	localparam logic [5:0] NEED = 6'h02;
	localparam logic [5:0] ADV = 6'h01;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	sqs_cmd_type cmd_code_i = SQS_CMD_NONE;
	logic [31:0] cmd_data_i = 32'h00000000;
	sqs_mode_type play_mode_i = SQS_MODE_ARB;
	logic [5:0] ctl = 6'h00;
	logic send = 1'b0;
	logic [24:0] send_val = 25'h0000000;
	logic ext_sel_valid_i;
	logic [24:0] ext_sel_i;
	logic resp_valid_o;
	logic [31:0] resp_data_o;
	logic cmd_refused_o;
	sqs_state_type seq_state_o;
	logic [24:0] entry_index_o;
	int err_count = 0;
	int n_checks = 0;
	int cycles = 0;

	////////////////////////////////////////
	// Clock, design and far-side port.
	always #50 clk_i = ~clk_i;
	sqs_core #(.IDX_W(25)) dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
		.cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .play_mode_i(play_mode_i),
		.run_i(ctl[5]), .stop_i(ctl[4]), .trigger_i(ctl[3]), .entry_done_i(ctl[2]),
		.need_advance_i(ctl[1]), .advance_i(ctl[0]), .ext_sel_valid_i(ext_sel_valid_i),
		.ext_sel_i(ext_sel_i), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
		.cmd_refused_o(cmd_refused_o), .seq_state_o(seq_state_o), .entry_index_o(entry_index_o));
	sqs_ext_sel_model ext_port (.clk_i(clk_i), .send_i(send), .val_i(send_val),
		.ext_sel_valid_o(ext_sel_valid_i), .ext_sel_o(ext_sel_i));

	////////////////////////////////////////
	// Shared tasks; every input changes on the falling edge.
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task cmd(input sqs_cmd_type c, input logic [31:0] d, input logic refused);
		logic seen;
		@(negedge clk_i);
		cmd_valid_i = 1'b1;
		cmd_code_i = c;
		cmd_data_i = d;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		seen = cmd_refused_o;
		@(negedge clk_i);
		seen = seen | cmd_refused_o;
		check("refused", {31'h0, refused}, {31'h0, seen});
	endtask : cmd

	// The index field is masked off in idle, where it carries no meaning.
	task query(input sqs_cmd_type c, input logic [31:0] exp, input logic [31:0] mask);
		logic v;
		@(negedge clk_i);
		cmd_valid_i = 1'b1;
		cmd_code_i = c;
		cmd_data_i = 32'h00000000;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		// The reply must stand exactly one cycle after the command; a late one is a mismatch.
		v = resp_valid_o;
		check("reply valid", 32'h1, {31'h0, v});
		check("reply", exp & mask, resp_data_o & mask);
	endtask : query

	task status(input logic [1:0] code, input logic [24:0] idx);
		query(SQS_CMD_STATE_QUERY, {5'h00, code, idx}, (code == SQS_CODE_IDLE) ? 32'hfe000000 : 32'hffffffff);
	endtask : status

	task step(input logic [5:0] v);
		@(negedge clk_i);
		ctl = v;
		@(negedge clk_i);
		ctl = 6'h00;
	endtask : step

	task ext(input logic [24:0] v);
		@(negedge clk_i);
		send = 1'b1;
		send_val = v;
		@(negedge clk_i);
		send = 1'b0;
		repeat (2) @(negedge clk_i);
	endtask : ext

	task final_report;
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	// A hang is cut short well beyond the roughly 125 cycles the tests need.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			final_report();
		end
	end

	////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		status(SQS_CODE_IDLE, 25'h0);
		query(SQS_CMD_DYN_EN_RD, 32'h0, 32'hffffffff);
		cmd(SQS_CMD_SEG_SEL_WR, 32'h00000003, 1'b0);
		cmd(SQS_CMD_SEQ_SEL_WR, 32'hfe000005, 1'b0);
		cmd(SQS_CMD_SCEN_SEL_WR, 32'h01ffffff, 1'b0);
		query(SQS_CMD_SEG_SEL_RD, 32'h3, 32'hffffffff);
		query(SQS_CMD_SEQ_SEL_RD, 32'h5, 32'hffffffff);
		query(SQS_CMD_SCEN_SEL_RD, 32'h01ffffff, 32'hffffffff);
		step(RUN);
		status(SQS_CODE_WAIT_TRIG, 25'h3);
		cmd(SQS_CMD_SEG_SEL_WR, 32'h7, 1'b1);
		cmd(SQS_CMD_NEXT_SEL_WR, 32'h9, 1'b1);
		step(TRIG);
		status(SQS_CODE_RUN, 25'h3);
		step(DONE);
		status(SQS_CODE_RUN, 25'h4);
		step(DONE | NEED);
		status(SQS_CODE_WAIT_ADV, 25'h4);
		step(ADV);
		status(SQS_CODE_RUN, 25'h5);
		check("state", {28'h0, SQS_ST_RUN}, {28'h0, seq_state_o});
		check("index", 32'h5, {7'h0, entry_index_o});
		step(STOP);
		status(SQS_CODE_IDLE, 25'h0);
		play_mode_i = SQS_MODE_SEQ;
		step(RUN);
		status(SQS_CODE_WAIT_TRIG, 25'h5);
		cmd(SQS_CMD_SEQ_SEL_WR, 32'h8, 1'b1);
		step(STOP);
		play_mode_i = SQS_MODE_SCEN;
		step(RUN);
		status(SQS_CODE_WAIT_TRIG, 25'h1ffffff);
		cmd(SQS_CMD_SCEN_SEL_WR, 32'h0, 1'b1);
		cmd(SQS_CMD_DYN_EN_WR, 32'h1, 1'b1);
		step(STOP);
		cmd(SQS_CMD_DYN_EN_WR, 32'h1, 1'b0);
		query(SQS_CMD_DYN_EN_RD, 32'h1, 32'hffffffff);
		play_mode_i = SQS_MODE_SEQ;
		step(RUN);
		status(SQS_CODE_WAIT_TRIG, 25'h5);
		step(TRIG);
		cmd(SQS_CMD_SEQ_SEL_WR, 32'h6, 1'b0);
		query(SQS_CMD_SEQ_SEL_RD, 32'h6, 32'hffffffff);
		cmd(SQS_CMD_NEXT_SEL_WR, 32'h14, 1'b0);
		status(SQS_CODE_RUN, 25'h5);
		step(DONE);
		status(SQS_CODE_RUN, 25'h14);
		ext(25'h11);
		step(DONE);
		status(SQS_CODE_RUN, 25'h11);
		step(DONE);
		status(SQS_CODE_RUN, 25'h12);
		// A dynamic choice made while waiting for advancement is taken at the advance.
		step(DONE | NEED);
		status(SQS_CODE_WAIT_ADV, 25'h12);
		cmd(SQS_CMD_NEXT_SEL_WR, 32'h30, 1'b0);
		step(ADV);
		status(SQS_CODE_RUN, 25'h30);
		step(STOP);
		final_report();
	end
endmodule : sequencer_state_and_dynamic_select_tb_top
